// [verilog/sac_ctrl.sv]
/*
 * Control and readout of a 12-bit successive-approximation converter.
 * Assumes pins are asynchronous, comparator decision arrives as a pin,
 * and the result lines are resolved from data/oe by the surroundings.
 */
// Functional notes
// RULE1 - Enabled: read when high, convert when low
// RULE2 - Disabled unit ignores all other inputs
// RULE3 - Enable rising or select falling starts
// RULE4 - Byte select low gives 12 bits
// RULE5 - Byte select high gives 8 bits
// RULE6 - Width select picks word or bytes
// RULE7 - Word read drives all twelve bits
// RULE8 - Byte read: MSB byte or LSB nibble
// RULE9 - LSB nibble sits high, zeros below
// RULE10 - Busy high from start until done
// RULE11 - Host sets convert before enabling unit
// RULE12 - Full-control and standalone modes both work
// RULE13 - Clear register, test MSB down to LSB
// RULE14 - Running conversion ignores starts, hides data
// RULE15 - Standalone: read high reads, falling converts
// RULE16 - Result lines float unless reading
// RULE17 - Length latched at start, held fixed
`timescale 1ns/1ps
module sac_ctrl
	import sac_pkg::*;
#(
	parameter int BIT_CYC = SAC_BIT_CYC
) (
	// Clock and reset
	input  wire logic        CLK_SYS,
	input  wire logic        ARST_N,
	// Bus controls
	input  wire logic        UNIT_ENABLE,
	input  wire logic        UNIT_SELECT_N,
	input  wire logic        READ_NOT_CONVERT,
	input  wire logic        BYTE_SELECT,
	input  wire logic        WORD_WIDTH_SELECT,
	// Comparator: high when trial value is not above the input
	input  wire logic        CMP_KEEP,
	// Status and conversion clock gate
	output logic             CONVERSION_BUSY,
	output logic             CONV_CLK_EN,
	// Result lines
	output logic [11:0]      RESULT_LINES_O,
	output logic [11:0]      RESULT_LINES_OE
);
	// ==========================================================
	// Input synchronisation
	sac_ctrl_t ctrl_raw;
	sac_ctrl_t ctrl_s;

	assign ctrl_raw = '{enable: UNIT_ENABLE, select_n: UNIT_SELECT_N,
		read_not_convert: READ_NOT_CONVERT, byte_select: BYTE_SELECT,
		word_width_select: WORD_WIDTH_SELECT};

	sac_sync #(.W(5)) u_sync_ctrl (
		.clk    (CLK_SYS),
		.arst_n (ARST_N),
		.d      (ctrl_raw),
		.q      (ctrl_s)
	);

	logic cmp_meta_r;
	logic cmp_s_r;

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			cmp_meta_r <= 1'b0;
			cmp_s_r    <= 1'b0;
		end else begin
			cmp_meta_r <= CMP_KEEP;
			cmp_s_r    <= cmp_meta_r;
		end
	end

	// ==========================================================
	// Command decode
	logic active;
	logic convert_lvl;
	logic read_lvl;
	logic convert_lvl_r;
	logic start;

	assign active      = ctrl_s.enable && !ctrl_s.select_n;             // RULE2
	assign convert_lvl = active && !ctrl_s.read_not_convert;            // RULE1
	assign read_lvl    = active && ctrl_s.read_not_convert;             // RULE1
	// One edge detector covers CE rise, CS fall and standalone R/C fall
	assign start       = convert_lvl && !convert_lvl_r;                 // RULE3 RULE15 RULE12

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			convert_lvl_r <= 1'b0;
		end else begin
			convert_lvl_r <= convert_lvl;
		end
	end

	// ==========================================================
	// Successive approximation sequencer
	sac_state_t  state_r, state_nxt;
	logic [11:0] sar_r, sar_nxt;
	logic [11:0] result_r, result_nxt;
	logic [3:0]  bit_r, bit_nxt;
	logic [3:0]  last_r, last_nxt;
	logic [7:0]  tick_r, tick_nxt;
	logic        tick_done;

	assign tick_done = (tick_r == 8'(BIT_CYC - 1));

	always_comb begin
		state_nxt  = state_r;
		sar_nxt    = sar_r;
		result_nxt = result_r;
		bit_nxt    = bit_r;
		last_nxt   = last_r;
		tick_nxt   = tick_r;
		unique case (state_r)
			SAC_IDLE: begin
				if (start) begin
					state_nxt = SAC_CLR;
					// Length chosen once here and held
					last_nxt  = ctrl_s.byte_select ? 4'(SAC_RES_W - SAC_SHORT_BITS)
						: 4'h0;                                             // RULE4 RULE5 RULE17
				end
			end
			SAC_CLR: begin
				sar_nxt   = SAC_RES_RST;                                  // RULE13
				bit_nxt   = 4'(SAC_MSB_POS);                              // RULE13
				tick_nxt  = 8'h00;
				state_nxt = SAC_TEST;
			end
			SAC_TEST: begin
				// Trial bit stays set while the comparator settles
				sar_nxt[bit_r] = 1'b1;
				if (tick_done) begin
					tick_nxt       = 8'h00;
					sar_nxt[bit_r] = cmp_s_r;                             // RULE13
					if (bit_r == last_r) begin
						state_nxt = SAC_DONE;
					end else begin
						bit_nxt = bit_r - 4'h1;                           // RULE13
					end
				end else begin
					tick_nxt = tick_r + 8'h01;
				end
			end
			SAC_DONE: begin
				result_nxt = sar_r;
				state_nxt  = SAC_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			state_r  <= SAC_IDLE;
			sar_r    <= SAC_RES_RST;
			result_r <= SAC_RES_RST;
			bit_r    <= 4'h0;
			last_r   <= 4'h0;
			tick_r   <= 8'h00;
		end else begin
			state_r  <= state_nxt;
			sar_r    <= sar_nxt;
			result_r <= result_nxt;
			bit_r    <= bit_nxt;
			last_r   <= last_nxt;
			tick_r   <= tick_nxt;
		end
	end

	// ==========================================================
	// Status
	logic busy_r, busy_nxt;

	assign busy_nxt = (state_nxt != SAC_IDLE);                          // RULE10 RULE14

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			busy_r <= 1'b0;
		end else begin
			busy_r <= busy_nxt;
		end
	end

	assign CONVERSION_BUSY = busy_r;
	assign CONV_CLK_EN     = busy_r;                                    // RULE13

	// ==========================================================
	// Result lines
	sac_bus_t lines;
	logic     rd_en;

	// No data while converting
	assign rd_en = read_lvl && (state_r == SAC_IDLE);                   // RULE14 RULE16

	sac_outbuf u_outbuf (
		.clk       (CLK_SYS),
		.arst_n    (ARST_N),
		.rd_en     (rd_en),
		.word_mode (ctrl_s.word_width_select),                          // RULE6
		.byte_sel  (ctrl_s.byte_select),
		.result    (result_r),
		.lines     (lines)
	);

	assign RESULT_LINES_O  = lines.data;
	assign RESULT_LINES_OE = lines.oe;

	// ==========================================================
	// Checks
	// Busy length counter for the checks; saturates so it never wraps
	logic [7:0] busy_cnt_r, busy_cnt_nxt;

	always_comb begin
		busy_cnt_nxt = busy_cnt_r;
		if (!busy_r) begin
			busy_cnt_nxt = 8'h00;
		end else if (busy_cnt_r != 8'hff) begin
			busy_cnt_nxt = busy_cnt_r + 8'h01;
		end
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			busy_cnt_r <= 8'h00;
		end else begin
			busy_cnt_r <= busy_cnt_nxt;
		end
	end

	sequence s_start;
		state_r == SAC_IDLE && start;
	endsequence

	sequence s_clear;
		state_r == SAC_CLR ##1 sar_r == 12'h000;
	endsequence

	sequence s_idle_conv;
		state_r == SAC_IDLE && ctrl_s.enable && !ctrl_s.read_not_convert;
	endsequence

	AST_START_BUSY: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // RULE10
		s_start |=> CONVERSION_BUSY && state_r == SAC_CLR)
		else $error("busy not raised at start");
	AST_CLEAR: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // RULE13
		s_start |=> s_clear ##0 bit_r == 4'hb)
		else $error("register not cleared before MSB test");
	AST_LEN12: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // RULE4
		(s_start and !ctrl_s.byte_select) |=> last_r == 4'h0)
		else $error("12-bit length not chosen");
	AST_LEN8: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // RULE5
		(s_start and ctrl_s.byte_select) |=> last_r == 4'h4)
		else $error("8-bit length not chosen");
	AST_LEN_HOLD: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // RULE17
		state_r != SAC_IDLE && state_nxt != SAC_IDLE |=> $stable(last_r))
		else $error("length changed mid conversion");
	AST_NO_DATA_BUSY: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // RULE14
		$past(busy_r) && busy_r |-> RESULT_LINES_OE == 12'h000)
		else $error("lines driven during conversion");
	AST_IDLE_FLOAT: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // RULE16
		!$past(read_lvl) |-> RESULT_LINES_OE == 12'h000)
		else $error("lines driven without read");
	AST_WORD: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // RULE7
		rd_en && ctrl_s.word_width_select |=> RESULT_LINES_OE == 12'hfff
		&& RESULT_LINES_O == $past(result_r))
		else $error("word read wrong");
	AST_LOW_NIB: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // RULE9
		rd_en && !ctrl_s.word_width_select && ctrl_s.byte_select |=>
		RESULT_LINES_OE == 12'h0ff && RESULT_LINES_O[7:0] == {$past(result_r[3:0]), 4'h0})
		else $error("low nibble byte wrong");
	AST_MSB_BYTE: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // RULE8
		rd_en && !ctrl_s.word_width_select && !ctrl_s.byte_select |=>
		RESULT_LINES_OE == 12'hff0 && RESULT_LINES_O[11:4] == $past(result_r[11:4]))
		else $error("high byte read wrong");
	AST_DONE_BUSY: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // RULE10
		state_r == SAC_DONE |=> !CONVERSION_BUSY)
		else $error("busy not lowered");
	// One clear cycle and one done cycle frame the bit decisions
	AST_BUSY_LEN: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // RULE10
		$fell(CONVERSION_BUSY) |-> busy_cnt_r == (last_r == 4'h0 ?
		8'(SAC_RES_W * BIT_CYC + 2) : 8'(SAC_SHORT_BITS * BIT_CYC + 2)))
		else $error("busy length wrong");
	AST_DISABLED: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // RULE2
		!active && state_r == SAC_IDLE |=> state_r == SAC_IDLE && RESULT_LINES_OE == 12'h000)
		else $error("disabled unit acted");
	AST_CONV_NO_DATA: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // RULE1
		convert_lvl |=> RESULT_LINES_OE == 12'h000)
		else $error("convert command drove lines");
	AST_READ_DRIVES: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // RULE1
		rd_en |=> RESULT_LINES_OE != 12'h000)
		else $error("read command drove nothing");
	AST_SEL_START: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // RULE3
		(s_idle_conv and $fell(ctrl_s.select_n)) |=> CONVERSION_BUSY)
		else $error("select fall did not start");
	AST_EN_START: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // RULE3
		(s_idle_conv and $rose(ctrl_s.enable) and !ctrl_s.select_n) |=> CONVERSION_BUSY)
		else $error("enable rise did not start");
	AST_RC_START: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // RULE15
		(s_idle_conv and $fell(ctrl_s.read_not_convert) and !ctrl_s.select_n) |=> CONVERSION_BUSY)
		else $error("read level fall did not start");
	AST_LOW_ZERO: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // RULE5
		state_r == SAC_DONE && last_r == 4'(SAC_RES_W - SAC_SHORT_BITS) |-> sar_r[3:0] == 4'h0)
		else $error("short result low bits not zero");
	AST_TRIAL_SET: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // RULE13
		state_r == SAC_TEST && tick_r != 8'h00 |-> sar_r[bit_r])
		else $error("trial bit not set while testing");
	AST_BIT_DOWN: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // RULE13
		state_r == SAC_TEST && tick_done && bit_r != last_r |=>
		state_r == SAC_TEST && bit_r == $past(bit_r) - 4'h1)
		else $error("bit order not MSB to LSB");
	AST_NO_RESTART: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // RULE14
		start && state_r != SAC_IDLE |=> state_r != SAC_CLR && $stable(last_r))
		else $error("start accepted while converting");
endmodule // sac_ctrl

// [verilog/sac_pkg.sv]
/*
 * Shared types and constants for the converter control block.
 * Assumes a single 100 MHz system clock and no register bus.
 */
package sac_pkg;

	// ==========================================================
	// Widths and timing
	localparam int          SAC_RES_W       = 12;
	localparam int          SAC_SHORT_BITS  = 8;
	localparam int          SAC_CLK_NS      = 10;
	// Time spent on each bit decision
	localparam int          SAC_BIT_NS      = 80;
	localparam int          SAC_BIT_CYC     = (SAC_BIT_NS + SAC_CLK_NS - 1) / SAC_CLK_NS;
	localparam logic [11:0] SAC_RES_RST     = 12'h000;
	localparam logic [3:0]  SAC_TRAIL_ZERO  = 4'h0;
	localparam int          SAC_MSB_POS     = 11;
	localparam int          SAC_LSB_NIB_POS = 4;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		SAC_IDLE = 2'b00,
		SAC_CLR  = 2'b01,
		SAC_TEST = 2'b11,
		SAC_DONE = 2'b10
	} sac_state_t;

	typedef struct packed {
		logic enable;
		logic select_n;
		logic read_not_convert;
		logic byte_select;
		logic word_width_select;
	} sac_ctrl_t;

	typedef struct packed {
		logic [11:0] data;
		logic [11:0] oe;
	} sac_bus_t;

endpackage

// [verilog/sac_sync.sv]
/*
 * Two flip-flop synchroniser for a group of asynchronous pins.
 * Assumes inputs are unrelated to CLK_SYS.
 */
`timescale 1ns/1ps
module sac_sync #(
	parameter int W = 5
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         arst_n,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule // sac_sync

// [verilog/sac_outbuf.sv]
/*
 * Result line formatter: picks word or byte layout and lane enables.
 * Assumes the result word is stable while a read is enabled.
 */
`timescale 1ns/1ps
module sac_outbuf
	import sac_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// Request
	input  wire logic        rd_en,
	input  wire logic        word_mode,
	input  wire logic        byte_sel,
	input  wire logic [11:0] result,
	// Lines
	output sac_bus_t         lines
);
	sac_bus_t lines_nxt;

	always_comb begin
		lines_nxt      = '0;
		if (rd_en) begin
			if (word_mode) begin
				lines_nxt.data = result;                            // RULE7
				lines_nxt.oe   = 12'hfff;                           // RULE7
			end else if (!byte_sel) begin
				lines_nxt.data = {result[11:4], SAC_TRAIL_ZERO};    // RULE8
				lines_nxt.oe   = 12'hff0;                           // RULE8
			end else begin
				// Low nibble moves up so byte lanes overlap on an 8-bit bus
				lines_nxt.data = {result[11:8], result[3:0], SAC_TRAIL_ZERO}; // RULE9
				lines_nxt.oe   = 12'h0ff;                           // RULE8
				lines_nxt.data[11:8] = result[11:8];
				lines_nxt.oe[11:8]   = 4'h0;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lines <= '0;
		end else begin
			lines <= lines_nxt;
		end
	end
endmodule // sac_outbuf

// [tb/sac_host_model.sv]
/*
 * Host-side model: data bus seen by the processor, plus comparator level.
 * Assumes the converter drives a line only while its enable bit is high.
 */
`timescale 1ns/1ps
module sac_host_model (
	// Clock
	input  wire logic        clk,
	// Lines from the converter
	input  wire logic [11:0] lines_o,
	input  wire logic [11:0] lines_oe,
	// Comparator level asked for by the bench
	input  wire logic        keep_lvl,
	// Host view
	output logic      [11:0] bus,
	output logic             cmp_keep
);
	// ==========================================================
	// Bus resolution with toggling floats
	logic [11:0] last_r = 12'h000;

	// Undriven bits flip every cycle so a float never passes for data
	always_ff @(posedge clk) begin
		last_r <= bus;
	end

	always_comb begin
		bus = (lines_o & lines_oe) | (~last_r & ~lines_oe);
	end

	assign cmp_keep = keep_lvl;
endmodule // sac_host_model

// [tb/sac_ctrl_tb.sv]
/*
 * Self-checking bench for sac_ctrl: bus-cycle tasks drive the pins.
 * Assumes a short bit time and the host model resolving the lines.
 */
`timescale 1ns/1ps
module sac_ctrl_tb
	import sac_pkg::*;
;
	// ==========================================================
	// Signals
	localparam int BC = 2;
	logic        clk_sys = 1'b0;
	logic        arst_n  = 1'b0;
	logic        keep    = 1'b1;
	sac_ctrl_t   ctl     = 5'h05;
	logic        busy;
	logic        clk_en;
	logic        cmp;
	logic [11:0] lo;
	logic [11:0] loe;
	logic [11:0] bus;
	int          num_errors = 0;
	int          compares   = 0;

	always #5 clk_sys = ~clk_sys;

	sac_ctrl #(.BIT_CYC(BC)) dut (
		.CLK_SYS(clk_sys), .ARST_N(arst_n), .UNIT_ENABLE(ctl.enable),
		.UNIT_SELECT_N(ctl.select_n), .READ_NOT_CONVERT(ctl.read_not_convert),
		.BYTE_SELECT(ctl.byte_select), .WORD_WIDTH_SELECT(ctl.word_width_select),
		.CMP_KEEP(cmp), .CONVERSION_BUSY(busy), .CONV_CLK_EN(clk_en),
		.RESULT_LINES_O(lo), .RESULT_LINES_OE(loe)
	);

	sac_host_model host (
		.clk(clk_sys), .lines_o(lo), .lines_oe(loe), .keep_lvl(keep),
		.bus(bus), .cmp_keep(cmp)
	);

	// ==========================================================
	// Tasks; pin codes are {enable, select_n, read, byte, width}
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic pins(input sac_ctrl_t v);
		@(posedge clk_sys);
		ctl <= v;
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	// Read cycle, then release and see the lines float again
	task automatic rd(input sac_ctrl_t v, input logic [11:0] exp_o, input logic [11:0] exp_oe);
		pins(v);
		tick(4);
		check(loe, exp_oe);
		check(bus & exp_oe, exp_o);
		pins(5'h05);
		tick(4);
		check(loe, 12'h000);
	endtask

	// Poke requests a read, flips the length pin, then re-requests a start
	task automatic convert(input sac_ctrl_t arm, input sac_ctrl_t go, input int nbits,
		input logic poke);
		int n;
		n = 0;
		pins(arm);
		pins(go);
		for (int i = 0; i < 300; i++) begin
			@(negedge clk_sys);
			if (busy !== 1'b1 && n > 0)
				break;
			if (busy === 1'b1)
				n++;
			if (n == 1)
				check(12'(clk_en), 12'h001);
			if (poke && n == 4)
				pins(go ^ 5'h06);
			if (poke && n == 8)
				check(loe, 12'h000);
			if (poke && n == 10)
				pins(go ^ 5'h02);
		end
		if (n == 0 || busy === 1'b1) begin
			num_errors++;
			summarize();
		end
		check(12'(n), 12'(2 + nbits * BC));
		check(12'(clk_en), 12'h000);
		pins(5'h05);
	endtask

	// ==========================================================
	// Sequence
	initial begin
		repeat (3) @(posedge clk_sys);
		arst_n <= 1'b1;
		tick(2);
		check(loe, 12'h000);
		pins(5'h19);
		tick(6);
		check(12'(busy), 12'h000);
		pins(5'h01);
		tick(6);
		check(12'(busy), 12'h000);
		pins(5'h05);
		tick(6);
		check(loe, 12'h000);
		convert(5'h01, 5'h11, 12, 1'b1);
		rd(5'h15, 12'hfff, 12'hfff);
		rd(5'h17, 12'hfff, 12'hfff);
		rd(5'h14, 12'hff0, 12'hff0);
		rd(5'h16, 12'h0f0, 12'h0ff);
		convert(5'h1b, 5'h13, 8, 1'b0);
		rd(5'h15, 12'hff0, 12'hfff);
		keep <= 1'b0;
		convert(5'h19, 5'h11, 12, 1'b0);
		rd(5'h15, 12'h000, 12'hfff);
		keep <= 1'b1;
		rd(5'h15, 12'h000, 12'hfff);
		convert(5'h15, 5'h11, 12, 1'b0);
		rd(5'h15, 12'hfff, 12'hfff);
		summarize();
	end
endmodule // sac_ctrl_tb
